// *** core/flash_host_regs.svh ***
// Register offsets, command codes, status bits and timing for the flash host controller.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STAT 8'h0C
`define REG_RDATA 8'h10
`define CTRL_GO_BIT 8
`define STAT_BUSY_BIT 8
`define STAT_SUSP_BIT 9
`define STAT_REFUSED_BIT 10
`define STAT_ERASING_BIT 11
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_PROGRAM_SETUP 8'h40
`define SR_READY 7
`define SR_SUSPENDED 6
`define SR_ERASE_FAIL 5
`define SR_PROGRAM_FAIL 4
`define SR_VOLTAGE_LOW 3
`define SR_USED_MASK 8'hF8
`define CLK_PERIOD_NS 10
`define T_SETUP_NS 20
`define T_PULSE_NS 60
`define T_HOLD_NS 20
`define T_RESET_NS 1000
`define SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC ((`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CYC ((`T_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** core/flash_host_pkg.sv ***
// Types shared by the flash host controller and its bus cycle engine.
`default_nettype none
package flash_host_pkg;
	typedef enum logic [2:0] {
		OP_READ_ARRAY = 3'b000,
		OP_READ_STATUS = 3'b001,
		OP_CLEAR = 3'b010,
		OP_ERASE = 3'b011,
		OP_SUSPEND = 3'b100,
		OP_RESUME = 3'b101,
		OP_PROGRAM = 3'b110,
		OP_RESET = 3'b111
	} op_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD1 = 3'b001,
		S_CMD2 = 3'b010,
		S_READ = 3'b011,
		S_POLL = 3'b100,
		S_CLEAR = 3'b101,
		S_RESET = 3'b110
	} state_t;
	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_SETUP = 2'b01,
		P_PULSE = 2'b10,
		P_HOLD = 2'b11
	} phase_t;
endpackage
`default_nettype wire

// *** core/flash_bus_cycle.sv ***
// One asynchronous write or read cycle on the flash pins.
`include "flash_host_regs.svh"
`default_nettype none
module flash_bus_cycle #(
	parameter int AW = 17
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] data_i,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rdata_o,
	output logic [AW-1:0] addr_o,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	input wire logic [7:0] dq_i,
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o
);
	import flash_host_pkg::*;
	phase_t phase_reg;
	logic [3:0] cnt_reg;
	logic write_reg;
	wire cnt_zero = (cnt_reg == 4'h0);
	assign busy_o = (phase_reg != P_IDLE);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_reg <= P_IDLE;
			cnt_reg <= 4'h0;
			write_reg <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 8'h00;
			addr_o <= '0;
			dq_o <= 8'h00;
			dq_oe_o <= 1'b0;
			ce_n_o <= 1'b1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
		end else begin
			done_o <= 1'b0;
			cnt_reg <= cnt_reg - 4'h1;
			case (phase_reg)
				P_IDLE: begin
					if (start_i) begin
						phase_reg <= P_SETUP;
						cnt_reg <= 4'(`SETUP_CYC - 1);
						write_reg <= write_i;
						addr_o <= addr_i;
						dq_o <= data_i;
						dq_oe_o <= write_i;
						ce_n_o <= 1'b0;
					end
				end
				P_SETUP: begin
					if (cnt_zero) begin
						phase_reg <= P_PULSE;
						cnt_reg <= 4'(`PULSE_CYC - 1);
						we_n_o <= ~write_reg;
						oe_n_o <= write_reg;
					end
				end
				P_PULSE: begin
					if (cnt_zero) begin
						// The device latches address and data on the rising write strobe.
						phase_reg <= P_HOLD;
						cnt_reg <= 4'(`HOLD_CYC - 1);
						we_n_o <= 1'b1;
						oe_n_o <= 1'b1;
						if (!write_reg) begin
							rdata_o <= dq_i;
						end
					end
				end
				P_HOLD: begin
					if (cnt_zero) begin
						phase_reg <= P_IDLE;
						ce_n_o <= 1'b1;
						dq_oe_o <= 1'b0;
						done_o <= 1'b1;
					end
				end
				default: begin
					phase_reg <= P_IDLE;
				end
			endcase
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_we_pulse_width: assert property ($fell(we_n_o) |-> !we_n_o[*6] ##1 we_n_o)
		else $error("write strobe width wrong");
	a_data_held_strobe: assert property (!we_n_o |-> dq_oe_o && !ce_n_o && $stable(dq_o))
		else $error("data not held under write strobe");
endmodule
`default_nettype wire

// *** core/flash_host.sv ***
// Wishbone-controlled host that drives a byte-wide flash through its command port.
// How it works
// - While suspended, read only other blocks.
// - Host clears status after low-supply indication.
// - Program is setup write, then address/data write.
// - Host checks program failure, clears if set.
// - Erase is setup then confirm in block.
`include "flash_host_regs.svh"
`default_nettype none
module flash_host #(
	parameter int AW = 17,
	parameter int BLK_LSB = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic [AW-1:0] flash_addr_o,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [7:0] flash_dq_i,
	output logic flash_ce_n_o,
	output logic flash_we_n_o,
	output logic flash_oe_n_o,
	output logic reset_powerdown_n_o
);
	import flash_host_pkg::*;
	state_t state_reg, state_next;
	op_t op_reg;
	logic [AW-1:0] addr_reg, susp_addr_reg;
	logic [7:0] wdata_reg, result_reg, status_reg;
	logic suspended_reg, erasing_reg, refused_reg, launched_reg, eng_start_reg, susp_pend_reg;
	logic [7:0] rst_cnt_reg;
	logic eng_busy, eng_done;
	logic [7:0] eng_rdata;

	// Register access decode.
	wire wb_access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_write = wb_access && wb_we_i;
	wire wr_ctrl = wb_write && (wb_adr_i == `REG_CTRL) && wb_sel_i[1];
	wire wr_addr = wb_write && (wb_adr_i == `REG_ADDR);
	wire wr_wdata = wb_write && (wb_adr_i == `REG_WDATA) && wb_sel_i[0];
	wire op_t op_w = op_t'(wb_dat_i[2:0]);
	wire go = wr_ctrl && wb_dat_i[`CTRL_GO_BIT];
	wire same_block = (addr_reg[AW-1:BLK_LSB] == susp_addr_reg[AW-1:BLK_LSB]);
	// A read of the block whose erase is paused would return garbage, so it is refused.
	wire guard_hit = suspended_reg && (op_w == OP_READ_ARRAY) && same_block;
	wire busy = (state_reg != S_IDLE);
	// An erase keeps the host busy until it ends, so a suspend is taken early and sent while the erase runs.
	wire susp_take = go && (op_w == OP_SUSPEND) && (op_reg == OP_ERASE) &&
		(state_reg == S_CMD1 || state_reg == S_CMD2 || state_reg == S_POLL);
	wire go_ok = go && !guard_hit && (!busy || susp_take);
	wire [31:0] stat_word = {20'h00000, erasing_reg, refused_reg, suspended_reg, busy, status_reg};
	wire [31:0] rd_mux = (wb_adr_i == `REG_CTRL) ? {29'h0, op_reg} :
		(wb_adr_i == `REG_ADDR) ? {{(32-AW){1'b0}}, addr_reg} :
		(wb_adr_i == `REG_WDATA) ? {24'h000000, wdata_reg} :
		(wb_adr_i == `REG_STAT) ? stat_word :
		(wb_adr_i == `REG_RDATA) ? {24'h000000, result_reg} : 32'h00000000;

	// Bus cycle contents for each step.
	wire [7:0] sr_used = eng_rdata & `SR_USED_MASK;
	wire sr_ready = sr_used[`SR_READY];
	wire sr_fail = sr_used[`SR_ERASE_FAIL] || sr_used[`SR_PROGRAM_FAIL] || sr_used[`SR_VOLTAGE_LOW];
	wire poll_ok = (op_reg == OP_SUSPEND) ? sr_ready : sr_ready;
	wire susp_jump = (state_reg == S_POLL) && eng_done && susp_pend_reg;
	wire poll_fin = (state_reg == S_POLL) && eng_done && poll_ok && !susp_pend_reg;
	wire want_clear = sr_fail && (op_reg != OP_SUSPEND);
	wire [7:0] cmd1_code = (op_reg == OP_READ_ARRAY) ? `CMD_READ_ARRAY :
		(op_reg == OP_READ_STATUS) ? `CMD_READ_STATUS :
		(op_reg == OP_CLEAR) ? `CMD_CLEAR_STATUS :
		(op_reg == OP_ERASE) ? `CMD_ERASE_SETUP :
		(op_reg == OP_SUSPEND) ? `CMD_SUSPEND :
		(op_reg == OP_RESUME) ? `CMD_CONFIRM : `CMD_PROGRAM_SETUP;
	// Erase setup is always followed by confirm, so the improper-sequence error never arises.
	wire [7:0] cmd2_code = (op_reg == OP_PROGRAM) ? wdata_reg : `CMD_CONFIRM;
	wire [7:0] eng_data = (state_reg == S_CMD1) ? cmd1_code :
		(state_reg == S_CMD2) ? cmd2_code : `CMD_CLEAR_STATUS;
	wire eng_write = (state_reg == S_CMD1) || (state_reg == S_CMD2) || (state_reg == S_CLEAR);
	wire cycle_state = eng_write || (state_reg == S_READ) || (state_reg == S_POLL);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (go_ok) begin
					state_next = (op_w == OP_RESET) ? S_RESET : S_CMD1;
				end
			end
			S_CMD1: begin
				if (eng_done) begin
					case (op_reg)
						OP_READ_ARRAY, OP_READ_STATUS: state_next = S_READ;
						OP_ERASE, OP_PROGRAM: state_next = S_CMD2;
						OP_SUSPEND, OP_RESUME: state_next = S_POLL;
						default: state_next = S_IDLE;
					endcase
				end
			end
			S_CMD2: begin
				if (eng_done) begin
					state_next = S_POLL;
				end
			end
			S_READ: begin
				if (eng_done) begin
					state_next = S_IDLE;
				end
			end
			S_POLL: begin
				if (susp_jump) begin
					state_next = S_CMD1;
				end else if (poll_fin) begin
					state_next = want_clear ? S_CLEAR : S_IDLE;
				end
			end
			S_CLEAR: begin
				if (eng_done) begin
					state_next = S_IDLE;
				end
			end
			S_RESET: begin
				if (rst_cnt_reg == 8'h00) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= S_IDLE;
			launched_reg <= 1'b0;
			eng_start_reg <= 1'b0;
			rst_cnt_reg <= 8'h00;
			reset_powerdown_n_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			eng_start_reg <= cycle_state && !launched_reg && !eng_busy && !eng_start_reg;
			launched_reg <= eng_done ? 1'b0 : (launched_reg || eng_start_reg);
			rst_cnt_reg <= (state_reg == S_RESET) ? rst_cnt_reg - 8'h01 : 8'(`RESET_CYC - 1);
			reset_powerdown_n_o <= (state_next != S_RESET);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_reg <= OP_READ_ARRAY;
			addr_reg <= '0;
			wdata_reg <= 8'h00;
			refused_reg <= 1'b0;
			susp_pend_reg <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_access;
			wb_dat_o <= wb_access ? rd_mux : 32'h00000000;
			if (go) begin
				refused_reg <= !go_ok;
			end
			if (go_ok && !busy) begin
				op_reg <= op_w;
			end else if (susp_jump) begin
				op_reg <= OP_SUSPEND;
			end
			if (susp_jump) begin
				susp_pend_reg <= 1'b0;
			end else if (susp_take) begin
				susp_pend_reg <= 1'b1;
			end
			if (wr_addr && !busy) begin
				addr_reg <= wb_dat_i[AW-1:0];
			end
			if (wr_wdata && !busy) begin
				wdata_reg <= wb_dat_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= 8'h00;
			result_reg <= 8'h00;
			suspended_reg <= 1'b0;
			erasing_reg <= 1'b0;
			susp_addr_reg <= '0;
		end else begin
			if ((state_reg == S_READ || state_reg == S_POLL) && eng_done) begin
				status_reg <= (op_reg == OP_READ_ARRAY) ? status_reg : sr_used;
				result_reg <= eng_rdata;
			end
			if (state_reg == S_CMD2 && eng_done && op_reg == OP_ERASE) begin
				erasing_reg <= 1'b1;
				susp_addr_reg <= addr_reg;
			end
			if (poll_fin) begin
				suspended_reg <= (op_reg == OP_SUSPEND) && sr_used[`SR_SUSPENDED];
				erasing_reg <= (op_reg == OP_SUSPEND) && sr_used[`SR_SUSPENDED];
			end
			if (state_reg == S_RESET) begin
				suspended_reg <= 1'b0;
				erasing_reg <= 1'b0;
			end
		end
	end

	flash_bus_cycle #(.AW(AW)) u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(eng_start_reg),
		.write_i(eng_write),
		.addr_i(addr_reg),
		.data_i(eng_data),
		.busy_o(eng_busy),
		.done_o(eng_done),
		.rdata_o(eng_rdata),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.dq_i(flash_dq_i),
		.ce_n_o(flash_ce_n_o),
		.we_n_o(flash_we_n_o),
		.oe_n_o(flash_oe_n_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_erase_confirm_next: assert property (state_reg == S_CMD1 && op_reg == OP_ERASE && eng_done |=> state_reg == S_CMD2 ##[1:3] eng_start_reg && eng_data == `CMD_CONFIRM)
		else $error("erase setup not followed by confirm");
	a_program_data_write: assert property (eng_start_reg && state_reg == S_CMD2 && op_reg == OP_PROGRAM |-> eng_write && eng_data == wdata_reg ##1 flash_dq_o == $past(wdata_reg))
		else $error("program data write wrong");
	a_fail_clears_status: assert property (poll_fin && want_clear |=> state_reg == S_CLEAR ##[1:3] eng_start_reg && eng_data == `CMD_CLEAR_STATUS)
		else $error("failed operation not cleared");
	a_low_supply_clear: assert property (poll_fin && sr_used[`SR_VOLTAGE_LOW] && op_reg == OP_PROGRAM |=> state_reg == S_CLEAR)
		else $error("low supply indication not cleared");
	a_block_guard: assert property (go && guard_hit |=> refused_reg && state_reg == S_IDLE)
		else $error("read of suspended block not refused");
	a_reserved_masked: assert property (state_reg == S_IDLE |-> status_reg[2:0] == 3'b000)
		else $error("reserved status bits leaked");
	a_suspend_sent_next: assert property (susp_jump |=> state_reg == S_CMD1 && op_reg == OP_SUSPEND)
		else $error("pending suspend not sent");
	a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_reset_pulse_low: assert property ($fell(reset_powerdown_n_o) |-> !reset_powerdown_n_o[*8])
		else $error("reset pulse too short");
	c_program_done: cover property (poll_fin && op_reg == OP_PROGRAM);
	c_erase_suspended: cover property (poll_fin && op_reg == OP_SUSPEND && sr_used[`SR_SUSPENDED]);
	c_read_refused: cover property (go && guard_hit);
	c_suspend_early: cover property (susp_jump);
endmodule
`default_nettype wire

// *** tb/flash_dev_model.sv ***
// Behavioural byte-wide flash device answering the host's command port.
`default_nettype none
module flash_dev_model #(
	parameter int PROG_T = 40,
	parameter int ERASE_T = 300,
	parameter int SUSP_T = 12
) (
	input wire logic clk_i,
	input wire logic rp_n_i,
	input wire logic [16:0] addr_i,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_i,
	output logic [7:0] dq_o,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic vpp_low_i,
	input wire logic fail_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sr, pd, pa;
	logic [7:0] last = 8'h00;
	logic we_q, stm, pbusy, ers, susp, sreq, eb;
	logic [1:0] pend;
	int cnt, scnt;
	wire logic [7:0] ra = {addr_i[12], addr_i[6:0]};
	wire logic [7:0] rv = stm ? {sr[7:3], 3'h0} : mem[ra];
	// A released bus shows the inverse of its last value, so a late sample cannot pass by luck.
	assign dq_o = (!ce_n_i && !oe_n_i) ? rv : ~last;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
	always @(posedge clk_i) begin
		we_q <= we_n_i;
		if (!ce_n_i && !oe_n_i) last <= rv;
		if (sreq) scnt <= scnt + 1;
		if (pbusy || (ers && !susp)) cnt <= cnt - 1;
		if (!rp_n_i) begin
			sr <= 8'h80;
			stm <= 1'b0;
			pend <= 2'd0;
			pbusy <= 1'b0;
			ers <= 1'b0;
			susp <= 1'b0;
			sreq <= 1'b0;
			scnt <= 0;
		end else if (we_n_i && !we_q && !ce_n_i && dq_oe_i) begin
			if (pend == 2'd1) begin
				pend <= 2'd0;
				if (dq_i != 8'hD0) sr[5:4] <= 2'b11;
				else if (vpp_low_i) sr[3] <= 1'b1;
				else begin
					ers <= 1'b1;
					eb <= addr_i[12];
					cnt <= ERASE_T;
					sr[7] <= 1'b0;
				end
			end else if (pend == 2'd2) begin
				pend <= 2'd0;
				if (vpp_low_i) sr[3] <= 1'b1;
				else begin
					pbusy <= 1'b1;
					pa <= ra;
					pd <= dq_i;
					cnt <= PROG_T;
					sr[7] <= 1'b0;
				end
			end else if (pbusy || (ers && !susp)) begin
				if (dq_i == 8'hB0 && ers) sreq <= 1'b1;
				stm <= 1'b1;
			end else if (susp && dq_i == 8'hD0) begin
				susp <= 1'b0;
				sr[7:6] <= 2'b00;
				stm <= 1'b1;
			end else if (!susp || dq_i == 8'hFF || dq_i == 8'h70) begin
				case (dq_i)
					8'hFF: stm <= 1'b0;
					8'h70: stm <= 1'b1;
					8'h50: sr[5:3] <= 3'h0;
					8'h20: pend <= 2'd1;
					8'h40: pend <= 2'd2;
					default: ;
				endcase
				if (dq_i == 8'h20 || dq_i == 8'h40) stm <= 1'b1;
			end
		end
		if (rp_n_i && pbusy && cnt == 0) begin
			pbusy <= 1'b0;
			sr[7] <= 1'b1;
			if (fail_i) sr[4] <= 1'b1;
			else mem[pa] <= mem[pa] & pd;
		end
		if (rp_n_i && ers && !susp && sreq && scnt == SUSP_T) begin
			susp <= 1'b1;
			sreq <= 1'b0;
			scnt <= 0;
			sr[7:6] <= 2'b11;
		end else if (rp_n_i && ers && !susp && cnt == 0) begin
			ers <= 1'b0;
			sreq <= 1'b0;
			sr[7] <= 1'b1;
			if (fail_i) sr[5] <= 1'b1;
			else for (int i = 0; i < 128; i++) mem[{eb, i[6:0]}] <= 8'hFF;
		end
	end
endmodule
`default_nettype wire

// *** tb/flash_host_tb.sv ***
// Self-checking bench for the flash host controller against a behavioural flash.
`include "flash_host_regs.svh"
`default_nettype none
module flash_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic chk; logic [31:0] exp; logic [31:0] msk;} note_t;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, vlow = 0, fail = 0;
	logic [7:0] adr = 0;
	logic [7:0] d0;
	logic [16:0] a0;
	logic [31:0] dw = 0, rd;
	wire logic [31:0] dr;
	wire logic ack, dq_oe, ce_n, we_n, oe_n, rp_n;
	wire logic [16:0] fa;
	wire logic [7:0] fdo, fdi;
	note_t q[$];
	int error_cnt = 0, total_checks = 0;
	always #5 clk_i = ~clk_i;
	flash_host i_flash_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .flash_addr_o(fa),
		.flash_dq_o(fdo), .flash_dq_oe_o(dq_oe), .flash_dq_i(fdi), .flash_ce_n_o(ce_n),
		.flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .reset_powerdown_n_o(rp_n));
	flash_dev_model i_flash_dev_model (.clk_i(clk_i), .rp_n_i(rp_n), .addr_i(fa), .dq_i(fdo), .dq_oe_i(dq_oe), .dq_o(fdi),
		.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .vpp_low_i(vlow), .fail_i(fail));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Each read leaves a note; the watcher below pairs it with the data seen at ack.
	always @(posedge clk_i) if (ack === 1'b1 && cyc && !we && q.size() > 0) begin
		note_t n;
		n = q.pop_front();
		if (n.chk) check(dr & n.msk, n.exp);
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
		input logic [31:0] e, input logic [31:0] m);
		int n;
		if (!w) q.push_back('{c, e, m});
		adr <= a;
		dw <= d;
		we <= w;
		cyc <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n >= 100) begin
			error_cnt++;
			end_sim();
		end
		rd = dr;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		wb(1'b0, a, 32'h0, 1'b1, e, m);
	endtask
	task automatic poll();
		int n;
		n = 0;
		do begin
			wb(1'b0, `REG_STAT, 32'h0, 1'b0, 32'h0, 32'h0);
			n++;
		end while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			error_cnt++;
			end_sim();
		end
	endtask
	task automatic op(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d, input logic wt);
		wb(1'b1, `REG_ADDR, {15'h0, a}, 1'b0, 32'h0, 32'h0);
		wb(1'b1, `REG_WDATA, {24'h0, d}, 1'b0, 32'h0, 32'h0);
		wb(1'b1, `REG_CTRL, {29'h0, o} | (32'h1 << `CTRL_GO_BIT), 1'b0, 32'h0, 32'h0);
		if (wt) poll();
	endtask
	initial begin
		void'($urandom(32'h82A3));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		d0 = 8'($urandom());
		a0 = {5'h0, 12'($urandom())};
		rdchk(`REG_STAT, 32'h0, 32'hFFF);
		wb(1'b1, 8'h20, 32'hFFFFFFFF, 1'b0, 32'h0, 32'h0);
		rdchk(8'h20, 32'h0, 32'hFFFFFFFF);
		$display("test reset and unmapped done");
		op(3'd6, a0, d0, 1'b1);
		rdchk(`REG_STAT, 32'h80, 32'hFFF);
		op(3'd0, a0, 8'h0, 1'b1);
		rdchk(`REG_RDATA, {24'h0, d0}, 32'hFF);
		vlow <= 1'b1;
		op(3'd6, a0 ^ 17'h1, 8'h0, 1'b1);
		rdchk(`REG_STAT, 32'h88, 32'hFFF);
		vlow <= 1'b0;
		op(3'd1, 17'h0, 8'h0, 1'b1);
		rdchk(`REG_RDATA, 32'h80, 32'hFF);
		op(3'd0, a0 ^ 17'h1, 8'h0, 1'b1);
		rdchk(`REG_RDATA, 32'hFF, 32'hFF);
		fail <= 1'b1;
		op(3'd6, a0 ^ 17'h2, 8'h0, 1'b1);
		rdchk(`REG_STAT, 32'h90, 32'hFFF);
		$display("test program done");
		for (int f = 0; f < 2; f++) begin
			fail <= f[0];
			op(3'd3, 17'h01000, 8'h0, 1'b1);
			rdchk(`REG_STAT, f[0] ? 32'hA0 : 32'h80, 32'hFFF);
		end
		fail <= 1'b0;
		$display("test erase done");
		op(3'd3, 17'h01000, 8'h0, 1'b0);
		op(3'd4, 17'h0, 8'h0, 1'b1);
		rdchk(`REG_STAT, 32'h2C0, 32'h3FF);
		op(3'd0, a0, 8'h0, 1'b1);
		rdchk(`REG_RDATA, {24'h0, d0}, 32'hFF);
		op(3'd0, {5'h01, 12'($urandom())}, 8'h0, 1'b1);
		rdchk(`REG_STAT, 32'h600, 32'h700);
		op(3'd5, 17'h0, 8'h0, 1'b1);
		rdchk(`REG_STAT, 32'h80, 32'h3FF);
		$display("test suspend done");
		op(3'd6, a0, 8'h0F, 1'b0);
		wb(1'b1, `REG_CTRL, 32'h101, 1'b0, 32'h0, 32'h0);
		rdchk(`REG_STAT, 32'h500, 32'h500);
		poll();
		op(3'd7, 17'h0, 8'h0, 1'b1);
		op(3'd0, a0, 8'h0, 1'b1);
		rdchk(`REG_RDATA, {24'h0, d0 & 8'h0F}, 32'hFF);
		$display("test refusal and reset done");
		end_sim();
	end
endmodule
`default_nettype wire
